// ==== shared/dsic_pkg.sv ====
// dsic_pkg: constants and types shared by both ends of the command link
// Contract
// - each command only in its listed formats
// - crc error or unknown code: no reply
// - decode the 4-bit command code table
// - master keeps minimum gap between frames; dsic_master leaves the spacing to software
// - reply in next transfer, exactly one
// - before init, all other commands unrecognized
// - init frame layout: code, address, data, crc; frame_word holds address, data, code from the msb down
// - reset address is stored address or zero
// - invalid bank select: no init reply
// - otp enable bit permits otp programming
// - init tests downstream node, sets fault
// - close switch only if no fault, requested
// - wait blanking time after closing switch
// - stored address: master sends it twice
// - unstored: address zero, new address given
// - address check fails: no assign, no reply
// - otp crc uses zero address value; no otp crc is computed here, dsic_slave leaves it to an external block
// - after init, ignore further init frames
// - init reply layout sixteen bits plus crc
// - fault flag one on fault, else zero
// - ignore init assigning address zero
package dsic_pkg;
  // ****************************************************************
  // frame formats and command codes
  // ****************************************************************
  typedef enum logic [1:0] {
    dsic_std_long, dsic_std_short, dsic_enh_long, dsic_enh_short
  } dsic_fmt_t;
  localparam logic [3:0] CMD_INIT = 4'h0;
  localparam logic [3:0] CMD_STATUS = 4'h1;
  localparam logic [3:0] CMD_ACCEL = 4'h2;
  localparam logic [3:0] CMD_ID = 4'h4;
  localparam logic [3:0] CMD_CLEAR = 4'h7;
  localparam logic [3:0] CMD_NVM = 4'h9;
  localparam logic [3:0] CMD_FORMAT = 4'ha;
  localparam logic [3:0] CMD_REGRD = 4'hb;
  localparam logic [3:0] CMD_ST_OFF = 4'hc;
  localparam logic [3:0] CMD_ST_ON = 4'hd;
  localparam logic [3:0] ADDR_NONE = 4'h0;
  // init data byte field positions
  localparam int OTP_EN_BIT = 7;
  localparam int SW_REQ_BIT = 6;
  localparam int BANK_HI = 5;
  localparam int BANK_LO = 4;
  localparam int NEWADDR_HI = 3;
  // reply layout
  localparam int RSP_FAULT_BIT = 8;
  localparam logic [2:0] RSP_ZERO = 3'h0;
  localparam logic [1:0] BANK_BAD = 2'h3;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ = 50;
  localparam int BLANK_US = 10;
  localparam int BLANK_CYC = BLANK_US * CLK_MHZ;
  localparam int TEST_CYC = 4;
  // apb map of the master controller
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_RSP = 8'h08;
  // 4-bit crc over a word, polynomial x^4+x+1, seed 1010
  function automatic logic [3:0] dsic_crc(input logic [19:0] d,
                                          input int n);
    logic [3:0] c;
    logic fb;
    c = 4'ha;
    for (int i = 19; i >= 0; i--) begin
      if (i < n) begin
        fb = c[3] ^ d[i];
        c = {c[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
      end
    end
    return c;
  endfunction : dsic_crc
endpackage : dsic_pkg

// ==== shared/dsic_link_if.sv ====
// dsic_link_if: frame level link between master and slave
`timescale 1ns/1ps
interface dsic_link_if;
  import dsic_pkg::*;
  logic frame_valid;
  dsic_pkg::dsic_fmt_t frame_fmt;
  logic [19:0] frame_word;
  logic [3:0] frame_crc;
  logic rsp_valid;
  logic [15:0] rsp_word;
  logic [3:0] rsp_crc;
  modport master (output frame_valid, frame_fmt, frame_word, frame_crc,
                  input rsp_valid, rsp_word, rsp_crc);
  modport slave (input frame_valid, frame_fmt, frame_word, frame_crc,
                 output rsp_valid, rsp_word, rsp_crc);
endinterface : dsic_link_if

// ==== core/dsic_slave.sv ====
// dsic_slave: slave command front end with full initialization
`timescale 1ns/1ps
module dsic_slave (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link to master
  dsic_link_if.slave link,
  // nonvolatile address and analog pins
  input wire logic [3:0] stored_address,
  input wire logic downstream_bus_node,
  // state toward the rest of the sensor
  output logic chain_switch_closed,
  output logic otp_prog_enable,
  output logic [1:0] nvm_bank,
  output logic [3:0] node_address,
  output logic initialized,
  output logic bus_fault_flag,
  output logic busy,
  output logic cmd_strobe,
  output logic [3:0] cmd_code,
  output logic [7:0] cmd_data
);
  import dsic_pkg::*;
  typedef enum {idle_s, test_s, blank_s} dsic_state_t;
  dsic_state_t state_q, state_d;
  logic [1:0] node_sync_q;
  logic load_q;
  logic [15:0] cnt_q;
  logic [7:0] init_data_q;
  logic [15:0] rsp_q;
  logic rsp_pend_q;
  logic [3:0] a_f, c_f;
  logic [7:0] d_f;
  logic crc_ok, fmt_ok, code_ok, addr_ok, init_ok, other_ok;
  logic [3:0] new_addr;
  logic [15:0] init_rsp;
  // ****************************************************************
  // frame decode
  // ****************************************************************
  assign d_f = link.frame_word[11:4];
  assign a_f = link.frame_word[15:12];
  assign c_f = link.frame_word[3:0];
  assign crc_ok = link.frame_crc == dsic_crc(link.frame_word, 16);
  assign new_addr = d_f[NEWADDR_HI:0];
  // formats allowed per code
  assign fmt_ok = (c_f == CMD_INIT)
    ? link.frame_fmt == dsic_std_long
    : (c_f == CMD_NVM || c_f == CMD_FORMAT || c_f == CMD_REGRD)
      ? (link.frame_fmt == dsic_std_long || link.frame_fmt == dsic_enh_long)
      : 1'b1;
  assign code_ok = c_f == CMD_INIT || c_f == CMD_STATUS
    || c_f == CMD_ACCEL || c_f == CMD_ID || c_f == CMD_CLEAR
    || c_f == CMD_NVM || c_f == CMD_FORMAT || c_f == CMD_REGRD
    || c_f == CMD_ST_OFF || c_f == CMD_ST_ON;
  // stored address must appear twice; unstored wants zero then new
  assign addr_ok = (stored_address != ADDR_NONE)
    ? (a_f == stored_address && new_addr == stored_address)
    : (a_f == ADDR_NONE);
  assign init_ok = link.frame_valid && crc_ok && fmt_ok
    && !initialized
    && c_f == CMD_INIT && addr_ok && new_addr != ADDR_NONE
    && d_f[BANK_HI:BANK_LO] != BANK_BAD && state_q == idle_s;
  assign other_ok = link.frame_valid && crc_ok && fmt_ok && code_ok
    && initialized && c_f != CMD_INIT
    && a_f == node_address;
  assign init_rsp = {init_data_q[NEWADDR_HI:0], RSP_ZERO,
                     node_sync_q[1], init_data_q};
  // ****************************************************************
  // init sequencer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      idle_s: if (init_ok) state_d = test_s;
      test_s: if (cnt_q == 16'(TEST_CYC - 1))
        state_d = (!node_sync_q[1] && init_data_q[SW_REQ_BIT]) ? blank_s
                                                              : idle_s;
      blank_s: if (cnt_q == 16'(BLANK_CYC - 1)) state_d = idle_s;
      default: state_d = idle_s;
    endcase
  end
  assign busy = state_q != idle_s;
  // accepted command handed on from flops, strobe aligned with its data
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_strobe <= 1'b0;
      cmd_code <= 4'h0;
      cmd_data <= 8'h00;
    end else begin
      cmd_strobe <= other_ok;
      if (other_ok) begin
        cmd_code <= c_f;
        cmd_data <= d_f;
      end
    end
  end
  // synchroniser for the downstream node, test sample
  always_ff @(posedge clk) begin
    node_sync_q <= {node_sync_q[0], downstream_bus_node};
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= idle_s;
      cnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_d != state_q) ? 16'h0000 : cnt_q + 16'h0001;
    end
  end
  // state bits; address loaded once after reset from storage
  always_ff @(posedge clk) begin
    if (reset) begin
      load_q <= 1'b1;
      node_address <= 4'h0;
      initialized <= 1'b0;
      otp_prog_enable <= 1'b0;
      nvm_bank <= 2'h0;
      chain_switch_closed <= 1'b0;
      bus_fault_flag <= 1'b0;
      init_data_q <= 8'h00;
    end else begin
      load_q <= 1'b0;
      if (load_q) node_address <= stored_address;
      if (init_ok) init_data_q <= d_f;
      if (state_q == test_s && state_d != test_s) begin
        node_address <= init_data_q[NEWADDR_HI:0];
        initialized <= 1'b1;
        otp_prog_enable <= init_data_q[OTP_EN_BIT];
        nvm_bank <= init_data_q[BANK_HI:BANK_LO];
        bus_fault_flag <= node_sync_q[1];
        chain_switch_closed <= state_d == blank_s;
      end
    end
  end
  // one reply, shown with the next frame; crc over the sixteen reply bits, address included
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_pend_q <= 1'b0;
      rsp_q <= 16'h0000;
      link.rsp_valid <= 1'b0;
      link.rsp_word <= 16'h0000;
      link.rsp_crc <= 4'h0;
    end else begin
      link.rsp_valid <= 1'b0;
      if (state_q == test_s && state_d != test_s) begin
        rsp_pend_q <= 1'b1;
        rsp_q <= init_rsp;
      end
      if (link.frame_valid && rsp_pend_q) begin
        link.rsp_valid <= 1'b1;
        link.rsp_word <= rsp_q;
        link.rsp_crc <= dsic_crc({4'h0, rsp_q}, 16);
        rsp_pend_q <= 1'b0;
      end
    end
  end
  // user otp crc is computed externally with address forced to zero
endmodule : dsic_slave

// ==== core/dsic_master.sv ====
// dsic_master: bus master end driven by apb registers
`timescale 1ns/1ps
module dsic_master (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to slave
  dsic_link_if.master link
);
  import dsic_pkg::*;
  logic [21:0] cmd_q;
  logic [15:0] rsp_q;
  logic rsp_seen_q;
  logic wr_cmd;
  // ****************************************************************
  // apb decode; a command word is {fmt[21:20], addr, data, code}
  // ****************************************************************
  assign wr_cmd = psel && penable && pwrite && paddr == REG_CMD;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_q <= 22'h0;
      prdata <= 32'h0;
    end else begin
      if (wr_cmd) cmd_q <= pwdata[21:0];
      if (psel && !penable) begin
        if (paddr == REG_CMD) prdata <= {10'h0, cmd_q};
        else if (paddr == REG_STAT) prdata <= {31'h0, rsp_seen_q};
        else if (paddr == REG_RSP) prdata <= {16'h0, rsp_q};
        else prdata <= 32'h0;
      end
    end
  end
  // one frame per command write; software spaces frames
  always_ff @(posedge clk) begin
    if (reset) begin
      link.frame_valid <= 1'b0;
      link.frame_fmt <= dsic_std_long;
      link.frame_word <= 20'h0;
      link.frame_crc <= 4'h0;
      rsp_q <= 16'h0;
      rsp_seen_q <= 1'b0;
    end else begin
      link.frame_valid <= wr_cmd;
      if (wr_cmd) begin
        link.frame_fmt <= dsic_fmt_t'(pwdata[21:20]);
        link.frame_word <= {4'h0, pwdata[15:0]};
        // bit 22 spoils the crc on purpose, to exercise the far checker
        link.frame_crc <= dsic_crc({4'h0, pwdata[15:0]}, 16)
                          ^ {3'h0, pwdata[22]};
      end
      if (link.rsp_valid) begin
        rsp_q <= link.rsp_word;
        rsp_seen_q <= 1'b1;
      end else if (wr_cmd) rsp_seen_q <= 1'b0;
    end
  end
endmodule : dsic_master

// ==== sim/dsic_link_properties.sv ====
// dsic_link_properties: link level assertions between master and slave
`timescale 1ns/1ps
module dsic_link_properties (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // frame from master
  input wire logic frame_valid,
  input wire logic [1:0] frame_fmt,
  input wire logic [19:0] frame_word,
  input wire logic [3:0] frame_crc,
  // reply from slave
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_word,
  input wire logic [3:0] rsp_crc
);
  import dsic_pkg::*;
  // ****************************
  // helper counters
  // ****************************
  localparam int GAP_MIN = TEST_CYC + BLANK_CYC + 2;
  int gap_q;
  int rsp_cnt_q;
  // cycles since last frame, saturating; replies since reset
  always_ff @(posedge clk) begin
    if (reset) begin
      gap_q <= GAP_MIN;
      rsp_cnt_q <= 0;
    end else begin
      gap_q <= frame_valid ? 1 : ((gap_q < GAP_MIN) ? gap_q + 1 : gap_q);
      rsp_cnt_q <= rsp_cnt_q + (rsp_valid ? 1 : 0);
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // reply one cycle after the triggering frame
  sequence s_reply;
    frame_valid ##1 rsp_valid;
  endsequence
  // reply crc worked out here: x^4+x+1 seeded with 1010, msb first
  function automatic logic [3:0] rsp_crc_of(input logic [15:0] d);
    logic [3:0] r;
    r = 4'ha;
    for (int i = 15; i >= 0; i--) begin
      r = {r[2:0], 1'b0} ^ ((r[3] ^ d[i]) ? 4'h3 : 4'h0);
    end
    return r;
  endfunction : rsp_crc_of
  AST_RSP_PULSE: assert property (s_reply |=> !rsp_valid)
    else $error("reply pulse longer than one cycle");
  AST_RSP_NEXT: assert property (
    rsp_valid |-> $past(frame_valid))
    else $error("reply not in the transfer after a frame");
  AST_RSP_HOLD: assert property ($changed(rsp_word) |-> rsp_valid)
    else $error("reply word changed without a reply");
  AST_RSP_LAYOUT: assert property (rsp_valid |->
    rsp_word[11:9] == RSP_ZERO && rsp_word[15:12] == rsp_word[3:0])
    else $error("reply layout wrong");
  AST_RSP_CRC: assert property (
    rsp_valid |-> rsp_crc == rsp_crc_of(rsp_word))
    else $error("reply crc wrong");
  AST_RSP_ADDR: assert property (
    rsp_valid |-> rsp_word[3:0] != ADDR_NONE)
    else $error("reply for address zero");
  AST_RSP_BANK: assert property (
    rsp_valid |-> rsp_word[5:4] != BANK_BAD)
    else $error("reply for invalid bank");
  AST_ONE_REPLY: assert property (rsp_valid |-> rsp_cnt_q == 0)
    else $error("second reply after initialization");
  AST_FRAME_GAP: assert property (
    frame_valid |-> gap_q >= GAP_MIN)
    else $error("frames closer than the minimum gap");
  AST_FRAME_TOP: assert property (
    frame_valid |-> frame_word[19:16] == 4'h0)
    else $error("frame word top nibble not zero");
  // enhanced short frames reach the link
  cover property (frame_valid && frame_fmt == dsic_enh_short);
endmodule : dsic_link_properties

// ==== sim/test_dsi_slave_cmd_init.sv ====
// test_dsi_slave_cmd_init: master driven over apb, slave driven by the master over the link
`timescale 1ns/1ps
module test_dsi_slave_cmd_init;
  import dsic_pkg::*;
  // ****************************
  // signals and instances
  // ****************************
  logic clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, cmd_data, dat;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] stored_address, node_address, cmd_code, a, c;
  logic bus_node, sw_closed, otp_en, inited, fault, strobe, ok, busy;
  logic [1:0] bank, bk;
  logic [11:0] got;
  logic [15:0] w;
  logic [19:0] rsp_last;
  dsic_fmt_t f;
  int bad_count = 0, checked = 0, n_strobe = 0, n_rsp = 0, cycles = 0, n0;
  dsic_link_if link ();
  dsic_master i_dsic_master (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  dsic_slave i_dsic_slave (.clk(clk), .reset(reset), .link(link),
    .stored_address(stored_address), .downstream_bus_node(bus_node),
    .chain_switch_closed(sw_closed), .otp_prog_enable(otp_en),
    .nvm_bank(bank), .node_address(node_address), .initialized(inited),
    .bus_fault_flag(fault), .busy(busy), .cmd_strobe(strobe),
    .cmd_code(cmd_code), .cmd_data(cmd_data));
  dsic_link_properties i_dsic_link_properties (.clk(clk), .reset(reset),
    .frame_valid(link.frame_valid), .frame_fmt(link.frame_fmt),
    .frame_word(link.frame_word), .frame_crc(link.frame_crc),
    .rsp_valid(link.rsp_valid), .rsp_word(link.rsp_word),
    .rsp_crc(link.rsp_crc));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // monitor strobes and replies; timeout well above the ~40k cycle run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (strobe === 1'b1) begin
      n_strobe <= n_strobe + 1;
      got <= {cmd_code, cmd_data};
    end
    if (link.rsp_valid === 1'b1) begin
      n_rsp <= n_rsp + 1;
      rsp_last <= {link.rsp_crc, link.rsp_word};
    end
    if (cycles == 60000) begin
      bad_count = bad_count + 1;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // own crc: x^4+x+1, seed 1010, msb first
  function automatic logic [3:0] crc16(input logic [15:0] d);
    logic [3:0] r;
    r = 4'ha;
    for (int i = 15; i >= 0; i--)
      r = {r[2:0], 1'b0} ^ ((r[3] ^ d[i]) ? 4'h3 : 4'h0);
    return r;
  endfunction : crc16
  function automatic logic accept(input logic [3:0] k, input dsic_fmt_t m);
    case (k)
      CMD_NVM, CMD_FORMAT, CMD_REGRD: return m == dsic_std_long ||
        m == dsic_enh_long;
      CMD_STATUS, CMD_ACCEL, CMD_ID, CMD_CLEAR, CMD_ST_OFF, CMD_ST_ON:
        return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : accept
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // one frame, then a wait past the minimum gap
  task automatic send(input dsic_fmt_t m, input logic [3:0] ad,
                      input logic [7:0] d, input logic [3:0] k);
    apb(1'b1, REG_CMD, {10'h0, m, 4'h0, ad, d, k});
    repeat (520) @(posedge clk);
  endtask : send
  task automatic restart(input logic [3:0] sa, input logic bn);
    stored_address <= sa;
    bus_node <= bn;
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    chk(node_address, sa);
    chk(inited, 1'b0);
  endtask : restart
  task automatic tally_and_finish();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // ****************************
  // main sequence
  // ****************************
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h0, 32'h0};
    {stored_address, bus_node} = 5'h0;
    void'($urandom(32'h9045));
    restart(4'h0, 1'b0);
    send(dsic_std_long, 4'h0, 8'h00, CMD_STATUS);
    chk(n_strobe, 0);
    for (int i = 0; i < 4; i++) begin
      a = 4'($urandom_range(15, 1));
      case (i)
        0: send(dsic_std_short, 4'h0, {4'h0, a}, CMD_INIT);
        1: send(dsic_std_long, 4'h0, {4'h3, a}, CMD_INIT);
        2: send(dsic_std_long, 4'h0, 8'h40, CMD_INIT);
        default: send(dsic_std_long, a, {4'h4, a ^ 4'h1}, CMD_INIT);
      endcase
      chk({22'h0, inited, sw_closed, 8'(n_rsp)}, 32'h0);
    end
    a = 4'($urandom_range(15, 1));
    bk = 2'($urandom_range(2, 0));
    dat = {2'b11, bk, a};
    // frame driven by hand so busy can be seen inside the blanking
    apb(1'b1, REG_CMD, {10'h0, dsic_std_long, 8'h00, dat, CMD_INIT});
    repeat (300) @(posedge clk);
    chk(busy, 1'b1);
    repeat (220) @(posedge clk);
    chk(busy, 1'b0);
    chk({inited, node_address, sw_closed, fault},
        {1'b1, a, 2'b10});
    chk({otp_en, bank}, {1'b1, bk});
    send(dsic_std_long, 4'h0, {4'hc, a ^ 4'h2}, CMD_INIT);
    chk(node_address, a);
    w = {a, 4'h0, dat};
    chk({12'(n_rsp), rsp_last}, {12'h1, crc16(w), w});
    for (int i = 0; i < 64; i++) begin
      c = 4'(i / 4 + 8);
      f = dsic_fmt_t'(i % 4);
      dat = 8'($urandom);
      n0 = n_strobe;
      ok = accept(c, f);
      send(f, a, dat, c);
      chk(n_strobe - n0, ok);
      if (ok)
        chk(got, {c, dat});
    end
    // a spoiled crc must leave a valid status command unseen
    n0 = n_strobe;
    apb(1'b1, REG_CMD,
        {9'h0, 1'b1, dsic_std_long, 4'h0, a, 8'h00, CMD_STATUS});
    repeat (520) @(posedge clk);
    chk(n_strobe - n0, 0);
    chk(n_rsp, 1);
    a = 4'($urandom_range(15, 1));
    restart(a, 1'b1);
    dat = {4'h5, a};
    send(dsic_std_long, a, dat, CMD_INIT);
    chk({fault, sw_closed, node_address}, {2'b10, a});
    send(dsic_std_long, a, 8'h00, CMD_STATUS);
    w = {a, 4'h1, dat};
    chk(rsp_last, {crc16(w), w});
    apb(1'b0, REG_STAT, 32'h0);
    chk({rd[0], pslverr}, 2'b10);
    apb(1'b0, REG_RSP, 32'h0);
    chk(rd, {16'h0, w});
    apb(1'b0, REG_CMD, 32'h0);
    chk(rd, {10'h0, dsic_std_long, 4'h0, a, 8'h00, CMD_STATUS});
    apb(1'b0, 8'h0c, 32'h0);
    tally_and_finish();
  end
endmodule : test_dsi_slave_cmd_init
